// >>> lpw_pkg.sv
`default_nettype none
package lpw_pkg;
  // control byte layout
  localparam int LPW_DT_LSB = 0;
  localparam int LPW_DT_MSB = 2;
  localparam int LPW_LOCK_BIT = 3;
  localparam int LPW_DIV_BIT = 4;
  localparam int LPW_RES_BIT = 6;
  localparam int LPW_STOP_BIT = 7;
  localparam logic [7:0] LPW_CTRL_RESET = 8'h47;
  localparam logic [7:0] LPW_PW_RESET = 8'h00;
  localparam logic [7:0] LPW_CTRL_USED = 8'hDF;
  // counter limits for 7-bit and 8-bit resolution
  localparam logic [7:0] LPW_CNT_MAX7 = 8'h7F;
  localparam logic [7:0] LPW_CNT_MAX8 = 8'hFF;
  localparam logic [3:0] LPW_DT_STEP = 4'h2;
  // half scale gives zero mean voltage on a full bridge
  localparam logic [7:0] LPW_PW_SAFE = 8'h80;
  // link target select
  localparam logic LPW_SEL_PW = 1'b0;
  localparam logic LPW_SEL_CTRL = 1'b1;
  // controller register offsets
  localparam logic [3:0] LPW_REG_PW = 4'h0;
  localparam logic [3:0] LPW_REG_CTRL = 4'h4;
  localparam logic [3:0] LPW_REG_RESET = 4'h8;
  localparam logic [3:0] LPW_REG_STATUS = 4'hC;
  localparam logic [1:0] LPW_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPW_RESP_SLVERR = 2'h2;

  function automatic logic [3:0] lpw_dt_clocks(input logic [7:0] ctrl);
    lpw_dt_clocks = 4'(ctrl[LPW_DT_MSB:LPW_DT_LSB] * LPW_DT_STEP);
  endfunction : lpw_dt_clocks

  // a locked control byte only lets the stop bit through
  function automatic logic [7:0] lpw_ctrl_merge(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = old;
    res[LPW_STOP_BIT] = wr[LPW_STOP_BIT];
    lpw_ctrl_merge = old[LPW_LOCK_BIT] ? res : (wr & LPW_CTRL_USED);
  endfunction : lpw_ctrl_merge
endpackage : lpw_pkg
`default_nettype wire

// >>> lpw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lpw_link_if;
  logic wr_strobe;
  logic sel;
  logic [7:0] data;
  logic rst_req;

  modport host (output wr_strobe, output sel, output data, output rst_req);
  modport device (input wr_strobe, input sel, input data, input rst_req);
endinterface : lpw_link_if
`default_nettype wire

// >>> lpw_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - reset loads control byte with 01000111
// - reset: stopped, 8-bit, undivided, unlocked, max dead-time
// - only reset clears the write lock
// - locked writes change only the stop field
// - reset clears the pulse-width number
// - no power-up reset; system must assert reset
// - unlocked write updates all fields at once
// - writer sets safe pulse width before control
// - writer sets lock during initial configuration; the host sets it only when software writes a control byte with bit 3 set
// - dead-time field 000 gives no dead-time
// - each turn-off holds both outputs low
// - on-time shorter than dead-time stays low
// - no dead-time at 0 and 100 percent
// - pulse width accepted at any moment
// - outputs follow new width three clocks later
// - width change acts within current period
// - writer clamps pulse width to 0..127 at 7-bit or 0..255 at 8-bit resolution
// - stop clear forces low, resume at period start
// - divide field halves the counter clock
// - resolution selects 128 or 256 count period
// - width writes while disabled stored, used later
module lpw_device
  import lpw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  lpw_link_if.device link,
  input wire logic output_enable_in,
  output logic primary_drive_output,
  output logic complementary_drive_output
);

  logic [7:0] ctrl;
  logic [7:0] pulse_width_number;
  logic [7:0] cnt;
  logic div_phase;
  logic [2:0] en_sync;
  logic en_pin;
  logic run;
  logic cmp_q;
  logic cmp_d;
  logic [3:0] dt_cnt;

  // the reset input of the generator is the system reset or the link request
  wire dev_rst;
  wire wr_pw;
  wire wr_ctrl;
  wire stop_ok;
  wire div_on;
  wire res8;
  wire cnt_tick;
  wire [7:0] cnt_max;
  wire period_end;
  wire full_scale;
  wire on_cond;
  wire dt_start;
  wire dt_idle;
  wire [3:0] dt_len;
  wire [7:0] next_cnt;
  wire [3:0] next_dt_cnt;
  wire next_run;

  assign dev_rst = !aresetn || link.rst_req;
  assign wr_pw = link.wr_strobe && (link.sel == LPW_SEL_PW);
  assign wr_ctrl = link.wr_strobe && (link.sel == LPW_SEL_CTRL);
  assign stop_ok = ctrl[LPW_STOP_BIT];
  assign div_on = ctrl[LPW_DIV_BIT];
  assign res8 = ctrl[LPW_RES_BIT];
  assign dt_len = lpw_dt_clocks(ctrl);

  // halving is an enable on every other clock, not a derived clock
  assign cnt_tick = !div_on || div_phase;
  assign cnt_max = res8 ? LPW_CNT_MAX8 : LPW_CNT_MAX7;
  // >= keeps a stale top bit from stretching the period after a mode change
  assign period_end = cnt_tick && (cnt >= cnt_max);
  assign next_cnt = period_end ? 8'h00 : (cnt_tick ? 8'(cnt + 8'h01) : cnt);

  // all-ones in the active resolution means permanently on
  assign full_scale = res8 ? (pulse_width_number == LPW_CNT_MAX8)
                           : (pulse_width_number[7] || (pulse_width_number[6:0] == LPW_CNT_MAX7[6:0]));
  // compare against the live width so a mid-period write acts at once
  assign on_cond = full_scale || (res8 ? (cnt < pulse_width_number)
                                       : (cnt[6:0] < pulse_width_number[6:0]));

  // any edge of the delayed comparator starts a dead interval
  assign dt_start = (cmp_q != cmp_d);
  assign dt_idle = (dt_cnt == 4'h0);
  assign next_dt_cnt = dt_start ? dt_len : (dt_idle ? 4'h0 : 4'(dt_cnt - 4'h1));

  // disable at once, re-enable only at the wrap of the counter
  assign next_run = (stop_ok && en_pin) ? (run || period_end) : 1'b0;

  // control byte
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      ctrl <= LPW_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl <= lpw_ctrl_merge(ctrl, link.data);
    end
  end

  // pulse-width latch, loaded on any cycle of the strobe
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      pulse_width_number <= LPW_PW_RESET;
    end
    else if (wr_pw)
    begin
      pulse_width_number <= link.data;
    end
  end

  // period counter and clock halving phase
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      cnt <= 8'h00;
      div_phase <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      div_phase <= !div_phase;
    end
  end

  // enable pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      en_sync <= 3'h0;
      en_pin <= 1'b0;
    end
    else
    begin
      en_sync <= {en_sync[1:0], output_enable_in};
      if (en_sync[1] == en_sync[2])
      begin
        en_pin <= en_sync[2];
      end
    end
  end

  // output enable state
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      run <= 1'b0;
    end
    else
    begin
      run <= next_run;
    end
  end

  // comparator pipeline: latch, compare, delay, output gives the three-clock response
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      cmp_q <= 1'b0;
      cmp_d <= 1'b0;
    end
    else
    begin
      cmp_q <= on_cond;
      cmp_d <= cmp_q;
    end
  end

  // dead-time counter; a re-trigger before expiry keeps both sides low
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      dt_cnt <= 4'h0;
    end
    else
    begin
      dt_cnt <= next_dt_cnt;
    end
  end

  // a steady comparator never starts a dead interval, so 0 and full duty pass clean
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      primary_drive_output <= 1'b0;
      complementary_drive_output <= 1'b0;
    end
    else
    begin
      primary_drive_output <= next_run && cmp_d && dt_idle;
      complementary_drive_output <= next_run && !cmp_d && dt_idle;
    end
  end

endmodule : lpw_device
`default_nettype wire

// >>> lpw_host.sv
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module lpw_host
  import lpw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  lpw_link_if.host link
);

  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic aw_held;
  logic w_held;
  logic pend_ctrl;
  logic pw_sent;
  logic [7:0] ctrl_shadow;
  logic [7:0] pw_shadow;
  logic [7:0] ctrl_hold;

  wire wr_go;
  wire [7:0] pw_limit;
  wire [7:0] pw_clamped;
  wire [31:0] rd_word;
  wire rd_hit;
  wire wr_hit;

  assign wr_go = aw_held && w_held && !s_axi_bvalid && !pend_ctrl;
  assign wr_hit = (aw_addr == LPW_REG_PW) || (aw_addr == LPW_REG_CTRL) || (aw_addr == LPW_REG_RESET);
  // signed value from software is saturated to the active resolution
  assign pw_limit = ctrl_shadow[LPW_RES_BIT] ? LPW_CNT_MAX8 : LPW_CNT_MAX7;
  assign pw_clamped = $signed(w_data) < 0 ? 8'h00
                    : (w_data > {24'h0, pw_limit}) ? pw_limit : w_data[7:0];
  assign rd_hit = (s_axi_araddr == LPW_REG_PW) || (s_axi_araddr == LPW_REG_CTRL)
               || (s_axi_araddr == LPW_REG_STATUS) || (s_axi_araddr == LPW_REG_RESET);
  assign rd_word = (s_axi_araddr == LPW_REG_PW) ? {24'h0, pw_shadow}
                 : (s_axi_araddr == LPW_REG_CTRL) ? {24'h0, ctrl_shadow}
                 : (s_axi_araddr == LPW_REG_STATUS) ? {30'h0, pw_sent, ctrl_shadow[LPW_LOCK_BIT]}
                 : 32'h0;

  // address and data are taken independently and held until executed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_go)
      begin
        aw_held <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      else if (wr_go)
      begin
        w_held <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // link side: one strobe per cycle; the device reset follows the system reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link.wr_strobe <= 1'b0;
      link.sel <= LPW_SEL_PW;
      link.data <= 8'h00;
      link.rst_req <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LPW_RESP_OKAY;
      pend_ctrl <= 1'b0;
      pw_sent <= 1'b0;
      ctrl_shadow <= LPW_CTRL_RESET;
      pw_shadow <= LPW_PW_RESET;
      ctrl_hold <= 8'h00;
    end
    else
    begin
      link.wr_strobe <= 1'b0;
      link.rst_req <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (pend_ctrl)
      begin
        link.wr_strobe <= 1'b1;
        link.sel <= LPW_SEL_CTRL;
        link.data <= ctrl_hold;
        ctrl_shadow <= lpw_ctrl_merge(ctrl_shadow, ctrl_hold);
        pend_ctrl <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (wr_go)
      begin
        s_axi_bresp <= wr_hit ? LPW_RESP_OKAY : LPW_RESP_SLVERR;
        s_axi_bvalid <= !(aw_addr == LPW_REG_CTRL && !pw_sent);
        if (aw_addr == LPW_REG_PW && s_axi_wstrb[0])
        begin
          link.wr_strobe <= 1'b1;
          link.sel <= LPW_SEL_PW;
          link.data <= pw_clamped;
          pw_shadow <= pw_clamped;
          pw_sent <= 1'b1;
        end
        else if (aw_addr == LPW_REG_CTRL && !pw_sent)
        begin
          // no width written yet: send the safe width first, control next cycle
          link.wr_strobe <= 1'b1;
          link.sel <= LPW_SEL_PW;
          link.data <= LPW_PW_SAFE;
          pw_shadow <= LPW_PW_SAFE;
          pw_sent <= 1'b1;
          pend_ctrl <= 1'b1;
          ctrl_hold <= w_data[7:0];
        end
        else if (aw_addr == LPW_REG_CTRL && s_axi_wstrb[0])
        begin
          link.wr_strobe <= 1'b1;
          link.sel <= LPW_SEL_CTRL;
          link.data <= w_data[7:0];
          ctrl_shadow <= lpw_ctrl_merge(ctrl_shadow, w_data[7:0]);
        end
        else if (aw_addr == LPW_REG_RESET && w_data[0])
        begin
          link.rst_req <= 1'b1;
          pw_sent <= 1'b0;
          ctrl_shadow <= LPW_CTRL_RESET;
          pw_shadow <= LPW_PW_RESET;
        end
      end
    end
  end

  // read channel: one read at a time, answer registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= LPW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? LPW_RESP_OKAY : LPW_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : lpw_host
`default_nettype wire

// >>> lpw_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lpw_link_assertions
  import lpw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_strobe,
  input wire logic sel,
  input wire logic [7:0] data,
  input wire logic rst_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic pw_seen;
  logic res8;
  logic locked;
  wire logic pw_wr = wr_strobe && (sel == LPW_SEL_PW);
  wire logic ctrl_wr = wr_strobe && (sel == LPW_SEL_CTRL);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || rst_req)
      pw_seen <= 1'b0;
    else if (pw_wr)
      pw_seen <= 1'b1;
  end

  // shadow of resolution, frozen once the lock is sent
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rst_req)
    begin
      res8 <= 1'b1;
      locked <= 1'b0;
    end
    else if (ctrl_wr && !locked)
    begin
      res8 <= data[LPW_RES_BIT];
      locked <= data[LPW_LOCK_BIT];
    end
  end

  property p_rst_req_after_reset;
    $past(aresetn) == 1'b0 |-> rst_req;
  endproperty
  a_rst_req_after_reset: assert property (p_rst_req_after_reset) else $error("no device reset after release");

  property p_rst_req_pulse;
    rst_req |=> !rst_req;
  endproperty
  a_rst_req_pulse: assert property (p_rst_req_pulse) else $error("device reset held too long");

  property p_no_strobe_in_reset;
    rst_req |-> !wr_strobe;
  endproperty
  a_no_strobe_in_reset: assert property (p_no_strobe_in_reset) else $error("write during device reset");

  property p_ctrl_after_pw;
    ctrl_wr |-> pw_seen;
  endproperty
  a_ctrl_after_pw: assert property (p_ctrl_after_pw) else $error("control sent before pulse width");

  property p_safe_first;
    (pw_wr && !pw_seen) ##1 ctrl_wr |-> $past(data) == LPW_PW_SAFE;
  endproperty
  a_safe_first: assert property (p_safe_first) else $error("first pulse width not safe");

  property p_clamp7;
    pw_wr && !res8 |-> !data[7];
  endproperty
  a_clamp7: assert property (p_clamp7) else $error("pulse width over 7-bit range");

  property p_pw_spacing;
    pw_wr |-> !$past(wr_strobe);
  endproperty
  a_pw_spacing: assert property (p_pw_spacing) else $error("pulse width strobe too close");

  property p_ctrl_pulse;
    ctrl_wr |=> !wr_strobe;
  endproperty
  a_ctrl_pulse: assert property (p_ctrl_pulse) else $error("control strobe longer than one cycle");
endmodule : lpw_link_assertions
`default_nettype wire

// >>> test_locked_deadtime_pwm_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_locked_deadtime_pwm_core
  import lpw_pkg::*;
;
  logic aclk = 0, aresetn = 0, oe = 1;
  logic [3:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, prim, comp;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  int bad_count = 0, compares = 0;

  always #5 aclk = ~aclk;

  lpw_link_if lpw_link_if_i ();
  lpw_host lpw_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(lpw_link_if_i));
  lpw_device lpw_device_i (.aclk(aclk), .aresetn(aresetn), .link(lpw_link_if_i), .output_enable_in(oe),
    .primary_drive_output(prim), .complementary_drive_output(comp));
  lpw_link_assertions lpw_link_assertions_i (.aclk(aclk), .aresetn(aresetn),
    .wr_strobe(lpw_link_if_i.wr_strobe), .sel(lpw_link_if_i.sel), .data(lpw_link_if_i.data),
    .rst_req(lpw_link_if_i.rst_req));

  task end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && awready === 1'b1)
      begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready === 1'b1)
      begin
        w = 0;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd

  // windows span whole periods, so the phase of the count does not matter
  task meas(input int n, input int ep, input int ec);
    int p;
    int c;
    p = 0;
    c = 0;
    repeat (n)
    begin
      @(posedge aclk);
      p += (prim === 1'b1);
      c += (comp === 1'b1);
    end
    chk("primary", p, ep);
    chk("complementary", c, ec);
  endtask : meas

  // one rising edge of the primary per period, so whole-period windows count periods exactly
  task edges(input int n, input int ee);
    int e;
    logic prev;
    e = 0;
    prev = prim;
    repeat (n)
    begin
      @(posedge aclk);
      e += (prim === 1'b1 && prev === 1'b0);
      prev = prim;
    end
    chk("rises", e, ee);
  endtask : edges

  task run(input logic [31:0] pw, input logic [31:0] ctrl, input int n, input int ep, input int ec);
    wr(LPW_REG_PW, pw);
    wr(LPW_REG_CTRL, ctrl);
    repeat (600) @(posedge aclk);
    meas(n, ep, ec);
  endtask : run

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(LPW_REG_CTRL);
    chk("ctrl", v, 32'h47);
    rd(LPW_REG_PW);
    chk("pw", v, 32'h0);
    rd(LPW_REG_STATUS);
    chk("status", v, 32'h0);
    meas(256, 0, 0);
    rd(4'h2);
    chk("rd resp", r, LPW_RESP_SLVERR);
    wr(4'h2, 32'h1);
    chk("wr resp", r, LPW_RESP_SLVERR);
    wr(LPW_REG_CTRL, 32'hC0);
    chk("wr resp", r, LPW_RESP_OKAY);
    rd(LPW_REG_PW);
    chk("safe pw", v, 32'h80);
    repeat (600) @(posedge aclk);
    meas(256, 128, 128);
    // strobe and bvalid rise together, so the pins change at the fourth edge after wr returns
    wr(LPW_REG_PW, 32'h0);
    wr(LPW_REG_PW, 32'hFF);
    repeat (3) @(posedge aclk);
    chk("primary before", prim, 1'b0);
    @(posedge aclk);
    chk("primary after", prim, 1'b1);
    chk("complementary after", comp, 1'b0);
    run(32'h80, 32'hC3, 256, 122, 122);
    run(32'h02, 32'hC3, 256, 0, 248);
    run(32'h00, 32'hC7, 256, 0, 256);
    run(32'hFF, 32'hC7, 256, 256, 0);
    run(32'h80, 32'hD0, 512, 256, 256);
    edges(1024, 2);
    run(32'h40, 32'h80, 256, 128, 128);
    edges(1024, 8);
    wr(LPW_REG_PW, 32'h190);
    rd(LPW_REG_PW);
    chk("clamp hi", v, 32'h7F);
    repeat (300) @(posedge aclk);
    meas(256, 256, 0);
    wr(LPW_REG_PW, 32'hFFFFFFF0);
    rd(LPW_REG_PW);
    chk("clamp lo", v, 32'h0);
    oe <= 0;
    repeat (8) @(posedge aclk);
    meas(256, 0, 0);
    wr(LPW_REG_PW, 32'h20);
    meas(256, 0, 0);
    oe <= 1;
    repeat (300) @(posedge aclk);
    meas(256, 64, 192);
    wr(LPW_REG_CTRL, 32'hC8);
    rd(LPW_REG_STATUS);
    chk("lock", v & 32'h1, 32'h1);
    wr(LPW_REG_CTRL, 32'h47);
    rd(LPW_REG_CTRL);
    chk("locked ctrl", v, 32'h48);
    repeat (3) @(posedge aclk);
    meas(256, 0, 0);
    // a locked write asking for the longest dead-time may only restart the outputs
    wr(LPW_REG_CTRL, 32'hC7);
    rd(LPW_REG_CTRL);
    chk("lock kept", v, 32'hC8);
    repeat (300) @(posedge aclk);
    meas(256, 32, 224);
    wr(LPW_REG_RESET, 32'h1);
    rd(LPW_REG_CTRL);
    chk("ctrl", v, 32'h47);
    rd(LPW_REG_PW);
    chk("pw", v, 32'h0);
    meas(256, 0, 0);
    end_of_test();
  end

  // the sequence needs about eleven and a half thousand cycles
  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
endmodule : test_locked_deadtime_pwm_core
`default_nettype wire
